// ---- shared/vepc_pkg.sv ----
// Shared constants and carrier types for the video encoder pin control block.
package vepc_pkg;

  // Clock rate and pixel path sizes.
  localparam int CLK_PERIOD_NS = 20;
  localparam int PIX_W = 16;
  localparam int OSD_W = 3;
  localparam int FIFO_DEPTH = 16;

  // Master timing generator geometry, counted in clock cycles and lines.
  localparam logic [10:0] LINE_CYCLES = 11'h6B4;
  localparam logic [10:0] HSYNC_CYCLES = 11'h080;
  localparam logic [8:0] FIELD_LINES = 9'h106;
  localparam logic [8:0] VSYNC_LINES = 9'h003;

  // Timing modes; the sync pins are used in modes 1 and 2 only.
  localparam logic [1:0] TMODE_0 = 2'h0;
  localparam logic [1:0] TMODE_1 = 2'h1;
  localparam logic [1:0] TMODE_2 = 2'h2;

  // Output channel selections.
  localparam logic [1:0] DAC_CVBS2_YC = 2'h0;

  // Upper six bits of the serial slave address; the value is arbitrary.
  localparam logic [5:0] SLAVE_ADDR_HI = 6'h2A;

  // Operating settings held by the block.
  typedef struct packed {
    logic std_pal;
    logic master;
    logic [1:0] tmode;
    logic wide;
    logic [1:0] dac_sel;
    logic clkout_select_bit_hi;
    logic clkout_select_bit_lo;
  } vepc_cfg_s;

  // Default settings: NTSC, slave, mode 0, 8-bit input, two composite plus Y/C, full clock.
  localparam vepc_cfg_s CFG_DEFAULT = '{std_pal: 1'b0, master: 1'b0, tmode: TMODE_0,
    wide: 1'b0, dac_sel: DAC_CVBS2_YC, clkout_select_bit_hi: 1'b0, clkout_select_bit_lo: 1'b0};

  // One captured pixel word with its overlay data.
  typedef struct packed {
    logic [PIX_W-1:0] pix;
    logic osd_on;
    logic [OSD_W-1:0] osd;
  } vepc_word_s;

  localparam int WORD_W = $bits(vepc_word_s);

endpackage

// ---- src/vepc_fifo.sv ----
// Flip-flop FIFO with valid and ready on both sides.
`timescale 1ns/1ps
module vepc_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic rst,
  // Filling side.
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Draining side.
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [AW:0] count_reg;
  logic push;
  logic pop;

  // Full and empty come straight from the occupancy count.
  assign in_ready = (count_reg != (AW+1)'(DEPTH));
  assign out_valid = (count_reg != '0);
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem_reg[rd_ptr_reg];

  // Storage is written without reset; only the pointers and the count carry state.
  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem_reg[wr_ptr_reg] <= in_data;
    end
  end

  // Pointers wrap naturally because the depth is a power of two.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end else begin
      if (push) wr_ptr_reg <= wr_ptr_reg + 1'b1;
      if (pop) rd_ptr_reg <= rd_ptr_reg + 1'b1;
      count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  // Occupancy never exceeds the depth.
  property p_fifo_bound;
    @(posedge sys_clk) disable iff (rst) count_reg <= (AW+1)'(DEPTH);
  endproperty
  a_fifo_bound: assert property (p_fifo_bound) else $error("FIFO overfilled.");

endmodule

// ---- src/vepc_pin_ctrl.sv ----
// Pin control and pixel input interface of a component to composite video encoder.
`timescale 1ns/1ps
//////////////////////////////////////////////////////////////////////////////////////////
// Function
// R1: A synchronous clock output runs at full or half rate as two select bits choose; the code parks it low for select 11 instead.
// R2: Pixels enter as 8-bit words on the low lines or 16-bit words, bit 0 least significant.
// R3: With the overlay enable high the overlay data goes to the video output, else it is unused.
// R4: The line-sync pin is used in timing modes 1 and 2, driven as master and sampled as slave.
// R5: The field/vertical pin carries field in mode 1 and vertical sync in mode 2, driven as master.
// R6: While the blanking control is low the pixel inputs are ignored.
// R7: The serial slave address takes its low bit from the address-select input.
// R8: Reset reinitialises the timing generator and returns all settings to their defaults.
// R9: Defaults are NTSC, slave, mode 0, 8-bit input and two composite plus luma/chroma outputs.
// R10: The serial clock is an input and the serial data line is bidirectional.
// R11: The source supplies a stable reference clock at the documented rate.
// R12: Inputs are sampled and master sync outputs launched on the rising clock edge.
//////////////////////////////////////////////////////////////////////////////////////////
module vepc_pin_ctrl
  import vepc_pkg::*;
(
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic rst,
  // Settings load.
  input wire logic cfg_load,
  input wire vepc_cfg_s cfg_in,
  output vepc_cfg_s cfg_out,
  // Synchronous clock output.
  output logic clkout,
  // Pixel input.
  input wire logic [PIX_W-1:0] pixel_bus,
  input wire logic blank_n,
  output logic pixel_ready,
  // Overlay input.
  input wire logic overlay_enable,
  input wire logic [OSD_W-1:0] osd_data,
  // Video word output.
  output logic video_valid,
  input wire logic video_ready,
  output vepc_word_s video_word,
  // Line-sync pin.
  input wire logic hsync_i,
  output logic hsync_o,
  output logic hsync_oe,
  // Field or vertical sync pin.
  input wire logic field_vsync_i,
  output logic field_vsync_o,
  output logic field_vsync_oe,
  // Sampled slave timing.
  output logic ext_hsync,
  output logic ext_field_vsync,
  // Serial host port.
  input wire logic bus_addr_low_bit,
  output logic [6:0] slave_addr,
  input wire logic host_serial_clock,
  input wire logic host_serial_data_i,
  output logic host_serial_data_o,
  output logic host_serial_data_oe,
  input wire logic serial_drive_low,
  output logic serial_clock_level,
  output logic serial_data_level
);

  vepc_cfg_s cfg_reg;
  logic div_reg;
  logic clkout_reg;
  logic [10:0] h_cnt_reg;
  logic [8:0] v_cnt_reg;
  logic field_reg;
  logic hsync_reg;
  logic fv_reg;
  logic ext_h_reg;
  logic ext_fv_reg;
  logic [6:0] addr_reg;
  logic scl_reg;
  logic sda_reg;
  logic pins_used;
  logic push_valid;
  vepc_word_s push_word;

  //////////////////////////////////////////////////////////////////////////////////////////
  // Settings: reset brings the defaults back, a load strobe takes new ones.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cfg_reg <= CFG_DEFAULT; // [R8] [R9]
    end else if (cfg_load) begin
      cfg_reg <= cfg_in;
    end
  end
  assign cfg_out = cfg_reg;

  //////////////////////////////////////////////////////////////////////////////////////////
  // Clock output: full rate toggles every cycle, half rate every other; select 11 parks it low.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      div_reg <= 1'b0;
      clkout_reg <= 1'b0;
    end else begin
      div_reg <= ~div_reg;
      if (cfg_reg.clkout_select_bit_hi && cfg_reg.clkout_select_bit_lo) begin
        clkout_reg <= 1'b0; // [R1]
      end else if (!cfg_reg.clkout_select_bit_lo || div_reg) begin
        clkout_reg <= ~clkout_reg; // [R1]
      end
    end
  end
  assign clkout = clkout_reg;

  //////////////////////////////////////////////////////////////////////////////////////////
  // Pixel capture: blanked cycles are dropped, narrow mode zeroes the upper lines.
  // A full FIFO stalls the source through pixel_ready rather than losing words.
  always_comb begin
    push_word.pix = cfg_reg.wide ? pixel_bus : {8'h00, pixel_bus[7:0]}; // [R2]
    push_word.osd_on = overlay_enable; // [R3]
    push_word.osd = overlay_enable ? osd_data : 3'h0; // [R3]
    push_valid = blank_n; // [R6] [R12]
  end

  vepc_fifo #(
    .WIDTH(WORD_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .sys_clk(sys_clk),
    .rst(rst),
    .in_valid(push_valid),
    .in_ready(pixel_ready),
    .in_data(push_word),
    .out_valid(video_valid),
    .out_ready(video_ready),
    .out_data(video_word)
  );

  //////////////////////////////////////////////////////////////////////////////////////////
  // Master timing generator; reset restarts it at the top of field 0.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      h_cnt_reg <= 11'h000; // [R8]
      v_cnt_reg <= 9'h000;
      field_reg <= 1'b0;
    end else if (h_cnt_reg == LINE_CYCLES - 11'h001) begin
      h_cnt_reg <= 11'h000;
      if (v_cnt_reg == FIELD_LINES - 9'h001) begin
        v_cnt_reg <= 9'h000;
        field_reg <= ~field_reg;
      end else begin
        v_cnt_reg <= v_cnt_reg + 9'h001;
      end
    end else begin
      h_cnt_reg <= h_cnt_reg + 11'h001;
    end
  end

  // Sync outputs are registered so they launch from the rising edge.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      hsync_reg <= 1'b0;
      fv_reg <= 1'b0;
    end else begin
      hsync_reg <= (h_cnt_reg < HSYNC_CYCLES); // [R12]
      fv_reg <= (cfg_reg.tmode == TMODE_1) ? field_reg : (v_cnt_reg < VSYNC_LINES); // [R5]
    end
  end

  // Pins are driven only by a master in mode 1 or 2.
  assign pins_used = (cfg_reg.tmode == TMODE_1) || (cfg_reg.tmode == TMODE_2);
  assign hsync_oe = cfg_reg.master && pins_used; // [R4]
  assign field_vsync_oe = cfg_reg.master && pins_used; // [R5]
  assign hsync_o = hsync_reg;
  assign field_vsync_o = fv_reg;

  // Slave sampling; levels read zero when the pins are not in use as inputs.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ext_h_reg <= 1'b0;
      ext_fv_reg <= 1'b0;
    end else begin
      ext_h_reg <= !cfg_reg.master && pins_used && hsync_i; // [R4] [R12]
      ext_fv_reg <= !cfg_reg.master && pins_used && field_vsync_i; // [R5]
    end
  end
  assign ext_hsync = ext_h_reg;
  assign ext_field_vsync = ext_fv_reg;

  //////////////////////////////////////////////////////////////////////////////////////////
  // Serial port pins: the address strap is caught by a clocked process on every clock, reset or not.
  always_ff @(posedge sys_clk) begin
    addr_reg <= {SLAVE_ADDR_HI, bus_addr_low_bit}; // [R7]
  end
  assign slave_addr = addr_reg;

  // The data line is open drain: it only ever pulls low.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      scl_reg <= 1'b1;
      sda_reg <= 1'b1;
    end else begin
      scl_reg <= host_serial_clock; // [R10]
      sda_reg <= host_serial_data_i; // [R10]
    end
  end
  assign serial_clock_level = scl_reg;
  assign serial_data_level = sda_reg;
  assign host_serial_data_o = 1'b0;
  assign host_serial_data_oe = serial_drive_low; // [R10]

  //////////////////////////////////////////////////////////////////////////////////////////
  // Checks.
  property p_clk_full;
    @(posedge sys_clk) disable iff (rst)
      (!cfg_reg.clkout_select_bit_lo && $stable(cfg_reg)) |=> (clkout != $past(clkout));
  endproperty
  a_clk_full: assert property (p_clk_full) else $error("Full clock missed a toggle."); // [R1]

  property p_clk_half;
    @(posedge sys_clk) disable iff (rst)
      (cfg_reg.clkout_select_bit_lo && !cfg_reg.clkout_select_bit_hi) [*3] |->
        (clkout ^ $past(clkout)) != ($past(clkout) ^ $past(clkout, 2));
  endproperty
  a_clk_half: assert property (p_clk_half) else $error("Half clock wrong rate."); // [R1]

  property p_narrow;
    @(posedge sys_clk) disable iff (rst)
      (push_valid && !cfg_reg.wide) |-> push_word.pix[15:8] == 8'h00;
  endproperty
  a_narrow: assert property (p_narrow) else $error("Narrow mode kept upper lines."); // [R2]

  property p_no_osd;
    @(posedge sys_clk) disable iff (rst) !overlay_enable |-> push_word.osd == 3'h0;
  endproperty
  a_no_osd: assert property (p_no_osd) else $error("Overlay leaked while disabled."); // [R3]

  property p_slave_float;
    @(posedge sys_clk) disable iff (rst) !cfg_reg.master |-> !hsync_oe && !field_vsync_oe;
  endproperty
  a_slave_float: assert property (p_slave_float) else $error("Slave drives sync pins."); // [R4]

  property p_field_mode;
    @(posedge sys_clk) disable iff (rst)
      (cfg_reg.tmode == TMODE_1) [*2] |-> field_vsync_o == $past(field_reg);
  endproperty
  a_field_mode: assert property (p_field_mode) else $error("Field output wrong."); // [R5]

  property p_blank;
    @(posedge sys_clk) disable iff (rst)
      (!blank_n && !video_ready) |=> $stable(video_valid) || !$rose(video_valid);
  endproperty
  a_blank: assert property (p_blank) else $error("Blanked pixel stored."); // [R6]

  property p_addr;
    @(posedge sys_clk) disable iff (rst) 1'b1 |=> slave_addr[0] == $past(bus_addr_low_bit);
  endproperty
  a_addr: assert property (p_addr) else $error("Address low bit wrong."); // [R7]

  property p_defaults;
    @(posedge sys_clk) rst |=> (cfg_reg == CFG_DEFAULT) && (h_cnt_reg == 11'h000);
  endproperty
  a_defaults: assert property (p_defaults) else $error("Defaults not restored."); // [R8] [R9]

  c_master_m2: cover property (@(posedge sys_clk) disable iff (rst)
    cfg_reg.master && cfg_reg.tmode == TMODE_2 && hsync_oe);
  c_fifo_full: cover property (@(posedge sys_clk) disable iff (rst) !pixel_ready);
  c_overlay: cover property (@(posedge sys_clk) disable iff (rst) video_valid && video_word.osd_on);

endmodule

// ---- testbench/tb.sv ----
// Self-checking bench for the video encoder pin control block.
`timescale 1ns/1ps
module tb
  import vepc_pkg::*;
;
  logic sys_clk = 1'b0, rst = 1'b1, cfg_load = 1'b0, src_en = 1'b0, video_ready = 1'b0;
  logic hsync_i = 1'b0, field_vsync_i = 1'b0, bus_addr_low_bit = 1'b0;
  logic host_serial_clock = 1'b1, host_serial_data_i = 1'b1, serial_drive_low = 1'b0;
  logic wide_mode = 1'b0, b, clkout, pixel_ready, blank_n, overlay_enable, video_valid;
  logic hsync_o, hsync_oe, field_vsync_o, field_vsync_oe, ext_hsync, ext_field_vsync;
  logic host_serial_data_o, host_serial_data_oe, serial_clock_level, serial_data_level;
  logic [PIX_W-1:0] pixel_bus;
  logic [OSD_W-1:0] osd_data;
  logic [6:0] slave_addr;
  vepc_cfg_s cfg_in = CFG_DEFAULT, cfg_out, c;
  vepc_word_s video_word, exp_w, exp_q[$];
  integer seed = 60650, mismatches = 0, num_checks = 0, cyc = 0, n;

  always #(CLK_PERIOD_NS / 2) sys_clk = ~sys_clk;
  vepc_source #(.SEED(60650)) src_u (.sys_clk(sys_clk), .rst(rst), .enable(src_en),
    .pixel_ready(pixel_ready), .pixel_bus(pixel_bus), .blank_n(blank_n),
    .overlay_enable(overlay_enable), .osd_data(osd_data));
  vepc_pin_ctrl dut_u (.sys_clk(sys_clk), .rst(rst), .cfg_load(cfg_load), .cfg_in(cfg_in),
    .cfg_out(cfg_out), .clkout(clkout), .pixel_bus(pixel_bus), .blank_n(blank_n),
    .pixel_ready(pixel_ready), .overlay_enable(overlay_enable), .osd_data(osd_data),
    .video_valid(video_valid), .video_ready(video_ready), .video_word(video_word),
    .hsync_i(hsync_i), .hsync_o(hsync_o), .hsync_oe(hsync_oe), .field_vsync_i(field_vsync_i),
    .field_vsync_o(field_vsync_o), .field_vsync_oe(field_vsync_oe), .ext_hsync(ext_hsync),
    .ext_field_vsync(ext_field_vsync), .bus_addr_low_bit(bus_addr_low_bit),
    .slave_addr(slave_addr), .host_serial_clock(host_serial_clock),
    .host_serial_data_i(host_serial_data_i), .host_serial_data_o(host_serial_data_o),
    .host_serial_data_oe(host_serial_data_oe), .serial_drive_low(serial_drive_low),
    .serial_clock_level(serial_clock_level), .serial_data_level(serial_data_level));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // Expected stored word: narrow mode keeps only the low eight pixel lines.
  function automatic vepc_word_s exp_word(input logic w, input logic [PIX_W-1:0] p,
      input logic oe, input logic [OSD_W-1:0] od);
    exp_word.pix = w ? p : {8'h00, p[7:0]};
    exp_word.osd_on = oe;
    exp_word.osd = od;
  endfunction
  // Expected clock output edges in 16 cycles: half rate gives 8, the parked code none.
  function automatic int exp_edges(input int s);
    return (s == 1) ? 8 : ((s == 3) ? 0 : 16);
  endfunction
  task automatic tick(input int k = 1);
    repeat (k) @(posedge sys_clk);
    #1;
  endtask
  task automatic load(input vepc_cfg_s v);
    cfg_in = v;
    cfg_load = 1'b1;
    tick();
    cfg_load = 1'b0;
    tick();
  endtask

  // Hang guard: the whole run needs well under 6000 cycles.
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 10000) begin
      mismatches++;
      summarize();
    end
  end

  // Scoreboard: words taken at the pixel port must leave in order, narrowed in 8-bit mode.
  always @(posedge sys_clk) begin
    if (!rst && blank_n && pixel_ready)
      exp_q.push_back(exp_word(wide_mode, pixel_bus, overlay_enable, osd_data));
    if (!rst && video_valid && video_ready) begin
      chk(exp_q.size() > 0, 1);
      exp_w = exp_q.pop_front();
      chk(video_word.pix, exp_w.pix);
      chk(video_word.osd_on, exp_w.osd_on);
      if (exp_w.osd_on) chk(video_word.osd, exp_w.osd);
    end
  end

  initial begin
    tick(20);
    rst = 1'b0;
    chk(cfg_out, CFG_DEFAULT);
    chk({hsync_oe, field_vsync_oe, video_valid, pixel_ready}, 4'h1);
    $display("test defaults done");
    // Strap and serial lines under random levels.
    for (int i = 0; i < 8; i++) begin
      n = $random(seed);
      {bus_addr_low_bit, serial_drive_low, host_serial_clock} = 3'(n);
      // Open-drain line with a pull-up: it reads low whenever the block pulls it.
      host_serial_data_i = n[3] && !n[1];
      tick();
      chk(slave_addr, {SLAVE_ADDR_HI, bus_addr_low_bit});
      chk({host_serial_data_oe, host_serial_data_o}, {serial_drive_low, 1'b0});
      chk(serial_clock_level, host_serial_clock);
      chk(serial_data_level, host_serial_data_i);
    end
    $display("test serial done");
    // Every clock-select code, counted as edges over 16 cycles.
    for (int s = 0; s < 4; s++) begin
      c = CFG_DEFAULT;
      {c.clkout_select_bit_hi, c.clkout_select_bit_lo} = 2'(s);
      load(c);
      tick(2);
      n = 0;
      repeat (16) begin
        b = clkout;
        tick();
        n += (b !== clkout);
      end
      chk(n, exp_edges(s));
      if (s == 3) chk(clkout, 0);
    end
    $display("test clock out done");
    // Pin direction per role and mode; slave samples arrive one cycle later.
    for (int m = 0; m < 6; m++) begin
      c = CFG_DEFAULT;
      c.master = 1'(m / 3);
      c.tmode = 2'(m % 3);
      load(c);
      chk({hsync_oe, field_vsync_oe}, {2{c.master && c.tmode != TMODE_0}});
      {hsync_i, field_vsync_i} = 2'($random(seed));
      tick();
      if (!c.master && c.tmode != TMODE_0)
        chk({ext_hsync, ext_field_vsync}, {hsync_i, field_vsync_i});
      else chk({ext_hsync, ext_field_vsync}, 0);
      // Early in the run the generator is still in the first lines of field 0.
      if (c.master && c.tmode != TMODE_0) chk(field_vsync_o, c.tmode == TMODE_2);
    end
    $display("test sync pins done");
    // Pixel stream, both widths: fill to refusal, drain with random stalls, then empty.
    for (int w = 0; w < 2; w++) begin
      c = CFG_DEFAULT;
      c.wide = 1'(w);
      load(c);
      wide_mode = 1'(w);
      // The consumer must stall here, or the previous drain would keep the FIFO from filling.
      video_ready = 1'b0;
      src_en = 1'b1;
      tick(60);
      chk(pixel_ready, 0);
      chk(exp_q.size(), FIFO_DEPTH);
      repeat (300) begin
        video_ready = 1'($random(seed));
        tick();
      end
      src_en = 1'b0;
      video_ready = 1'b1;
      tick(40);
      chk({exp_q.size() == 0, video_valid}, 2'h2);
    end
    $display("test pixel stream done");
    // Master line timing: 128 sync cycles in one 1716-cycle line.
    c = CFG_DEFAULT;
    c.master = 1'b1;
    c.tmode = TMODE_2;
    load(c);
    n = 0;
    repeat (1716) begin
      tick();
      n += (hsync_o === 1'b1);
    end
    chk(n, 128);
    $display("test master line done");
    // Reset in mid-run returns settings and pins to defaults.
    rst = 1'b1;
    tick(2);
    rst = 1'b0;
    chk(cfg_out, CFG_DEFAULT);
    chk({hsync_o, hsync_oe, field_vsync_oe}, 0);
    $display("test reset done");
    summarize();
  end
endmodule

// ---- testbench/vepc_source.sv ----
// Behavioural video source that feeds pixel words and overlay data.
`timescale 1ns/1ps
module vepc_source
  import vepc_pkg::*;
#(
  parameter int SEED = 60650
) (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic enable,
  // Pixel port.
  input wire logic pixel_ready,
  output logic [PIX_W-1:0] pixel_bus,
  output logic blank_n,
  output logic overlay_enable,
  output logic [OSD_W-1:0] osd_data
);
  integer seed = SEED;
  initial begin
    pixel_bus = 16'h0000;
    blank_n = 1'b0;
    overlay_enable = 1'b0;
    osd_data = 3'h0;
  end
  // A word offered is held until taken; idle lines keep changing so stale data cannot pass.
  always @(posedge sys_clk) begin
    if (rst || !enable) begin
      blank_n <= #1 1'b0;
      pixel_bus <= #1 ~pixel_bus;
    end else if (!blank_n || pixel_ready) begin
      blank_n <= #1 ($random(seed) % 4) != 0;
      pixel_bus <= #1 16'($random(seed));
      overlay_enable <= #1 1'($random(seed));
      osd_data <= #1 3'($random(seed));
    end
  end
endmodule
